// ---- sar_dev.sv ----
// Converter end: conversion timing, result word and serial readout
//
// Function
// - Convert rising edge starts a new conversion.
// - Busy high during conversion, 460..527 ns.
// - Host spaces convert edges one microsecond.
// - Host holds convert high, low 20 ns.
// - Host keeps serial clock quiet 20 ns.
// - Chain low means normal mode, pin enables.
// - Read enable low drives output, high releases.
// - Chain high makes shared pin serial input.
// - Result shifts out MSB first, rising edges.
// - Chain mode forwards upstream bits downstream.
// - Result coded as two's complement.
// - MSB appears when busy falls, no clock.
// - Normal mode serial clock period 10 ns.
// - Chain mode serial clock period 13.5 ns.
// - Gain compression maps to 10..90 percent.
// - Word belongs to the conversion just ended.
`timescale 1ns/1ns
module sar_dev
  import sar_pkg::*;
#(
  parameter int WIDTH = RES_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link pins
  sar_link_if.dev link,
  // Sampled analog value as an unsigned offset code
  input wire logic [WIDTH-1:0] sample_code,
  // Gain compression select, high means none
  input wire logic gain_compression_select
);
  initial begin
    if (WIDTH != 16) $error("sar_dev serves a 16-bit word only");
  end

  typedef enum logic [0:0] {ST_IDLE, ST_CONV} sar_state_e;

  // Two-flop synchronisers for pin inputs
  logic [1:0] cnv_s_q, sck_s_q, chn_s_q, rin_s_q;
  logic cnv_last_q, sck_last_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnv_s_q <= 2'h0;
      sck_s_q <= 2'h0;
      chn_s_q <= 2'h0;
      rin_s_q <= 2'h3;
      cnv_last_q <= 1'b0;
      sck_last_q <= 1'b0;
    end else begin
      cnv_s_q <= {cnv_s_q[0], link.convert_start};
      sck_s_q <= {sck_s_q[0], link.sck};
      chn_s_q <= {chn_s_q[0], link.chain};
      rin_s_q <= {rin_s_q[0], link.read_enable_or_chain_in};
      cnv_last_q <= cnv_s_q[1];
      sck_last_q <= sck_s_q[1];
    end
  end

  logic cnv_rise, sck_rise, chain_mode, pin_in;
  assign cnv_rise = cnv_s_q[1] & ~cnv_last_q;
  assign sck_rise = sck_s_q[1] & ~sck_last_q;
  assign chain_mode = chn_s_q[1];
  assign pin_in = rin_s_q[1];

  // Gain compression: code*0.8 + 0.1*full scale, then to two's complement
  function automatic logic [15:0] sar_code(input logic [15:0] raw,
                                           input logic gc_off);
    logic [31:0] scaled;
    logic [15:0] unsig;
    scaled = 32'h0;
    unsig = raw;
    if (!gc_off) begin
      // Integer 4/5 scale leaves a small rounding loss, accepted
      scaled = ({16'h0000, raw} * 32'h0000_0004) / 32'h0000_0005;
      unsig = scaled[15:0] + 16'h199A;
    end
    // Flip the MSB: offset binary to two's complement
    return {~unsig[15], unsig[14:0]};
  endfunction

  sar_state_e state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] shreg_q, shreg_d;
  logic busy_q, busy_d;

  // Conversion sequencer and shifter, next values
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shreg_d = shreg_q;
    busy_d = busy_q;
    case (state_q)
      ST_IDLE: begin
        if (cnv_rise) begin
          state_d = ST_CONV;
          busy_d = 1'b1;
          cnt_d = 16'h0000;
        end else if (sck_rise) begin
          shreg_d = {shreg_q[14:0], chain_mode ? pin_in : 1'b0};
        end
      end
      ST_CONV: begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q == 16'(CONV_CYC - 1)) begin
          state_d = ST_IDLE;
          busy_d = 1'b0;
          shreg_d = sar_code(sample_code, gain_compression_select);
        end
      end
      default: begin
        state_d = ST_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 16'h0000;
      shreg_q <= RESULT_RST;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shreg_q <= shreg_d;
      busy_q <= busy_d;
    end
  end

  assign link.sdo_o = shreg_q[15];
  assign link.busy = busy_q;
  assign link.sdo_oe = chain_mode | ~pin_in;
endmodule

// ---- sar_host.sv ----
// Host end: convert pulses, busy wait and serial result capture
`timescale 1ns/1ns
module sar_host
  import sar_pkg::*;
#(
  parameter int WIDTH = RES_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link pins
  sar_link_if.host link,
  // User side
  input wire logic start,
  input wire logic chain_sel,
  output logic ready,
  output logic [WIDTH-1:0] result,
  output logic result_valid
);
  initial begin
    if (WIDTH != 16) $error("sar_host serves a 16-bit word only");
  end

  typedef enum logic [2:0] {
    HS_IDLE, HS_HIGH, HS_WAIT, HS_SHIFT, HS_GAP
  } sar_hstate_e;

  // Busy comes from another party: two flops
  logic [1:0] busy_s_q, sdo_s_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_s_q <= 2'h0;
      sdo_s_q <= 2'h0;
    end else begin
      busy_s_q <= {busy_s_q[0], link.busy};
      sdo_s_q <= {sdo_s_q[0], link.sdo};
    end
  end

  sar_hstate_e st_q, st_d;
  logic [15:0] tmr_q, tmr_d, per_q, per_d;
  logic [4:0] bits_q, bits_d;
  logic sck_q, sck_d, cnv_q, cnv_d;
  logic [WIDTH-1:0] res_q, res_d;
  logic val_q, val_d;

  // Host sequence, next values
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q + 16'h0001;
    per_d = per_q + 16'h0001;
    bits_d = bits_q;
    sck_d = sck_q;
    cnv_d = cnv_q;
    res_d = res_q;
    val_d = 1'b0;
    case (st_q)
      HS_IDLE: begin
        // edge spacing kept by period timer
        if (start && per_q >= 16'(CYC_CYC)) begin
          st_d = HS_HIGH;
          cnv_d = 1'b1;
          tmr_d = 16'h0000;
          per_d = 16'h0000;
        end
      end
      HS_HIGH: begin
        if (tmr_q >= 16'(CNV_HL_CYC + QUIET_CYC)) begin
          cnv_d = 1'b0;
          st_d = HS_WAIT;
          tmr_d = 16'h0000;
        end
      end
      HS_WAIT: begin
        // wait for busy low, allow sync lag
        if (tmr_q >= 16'(CONV_MAX_CYC + 4) && !busy_s_q[1]) begin
          st_d = HS_SHIFT;
          tmr_d = 16'h0000;
          bits_d = 5'h00;
        end
      end
      HS_SHIFT: begin
        if (tmr_q == 16'(SCK_HALF_CYC - 1)) begin
          tmr_d = 16'h0000;
          if (!sck_q) begin
            // Sample before the rising edge moves the bit
            res_d = {res_q[WIDTH-2:0], sdo_s_q[1]};
            sck_d = 1'b1;
          end else begin
            sck_d = 1'b0;
            bits_d = bits_q + 5'h01;
            if (bits_q == 5'(WIDTH - 1)) begin
              st_d = HS_GAP;
              val_d = 1'b1;
            end
          end
        end
      end
      HS_GAP: begin
        // Sync lag settles before waiting for busy again
        st_d = HS_IDLE;
      end
      default: st_d = HS_IDLE;
    endcase
    if (per_q == 16'hFFFF) per_d = per_q;
  end

  // Host registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= HS_IDLE;
      tmr_q <= 16'h0000;
      per_q <= 16'hFFFF;
      bits_q <= 5'h00;
      sck_q <= 1'b0;
      cnv_q <= 1'b0;
      res_q <= '0;
      val_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      per_q <= per_d;
      bits_q <= bits_d;
      sck_q <= sck_d;
      cnv_q <= cnv_d;
      res_q <= res_d;
      val_q <= val_d;
    end
  end

  assign link.convert_start = cnv_q;
  assign link.sck = sck_q;
  assign link.chain = chain_sel;
  // Normal mode: read enable held low; chain mode: zero into chain
  assign link.read_enable_or_chain_in = 1'b0;
  assign ready = (st_q == HS_IDLE);
  assign result = res_q;
  assign result_valid = val_q;
endmodule

// ---- sar_link_if.sv ----
// Pin-level link between converter and host
`timescale 1ns/1ns
interface sar_link_if;
  logic convert_start;
  logic busy;
  logic sck;
  logic chain;
  logic read_enable_or_chain_in;
  logic sdo_o;
  logic sdo_oe;
  logic sdo;
  // Released line reads high through a weak pull
  assign sdo = sdo_oe ? sdo_o : 1'b1;
  modport dev (input convert_start, sck, chain, read_enable_or_chain_in,
    output busy, sdo_o, sdo_oe);
  modport host (output convert_start, sck, chain, read_enable_or_chain_in,
    input busy, sdo);
endinterface

// ---- sar_link_monitor.sv ----
// Checker for the converter readout link
`timescale 1ns/1ns
module sar_link_monitor
  import sar_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link signals
  input wire logic convert_start,
  input wire logic busy,
  input wire logic sck,
  input wire logic chain,
  input wire logic read_enable_or_chain_in,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  logic [7:0] gap_q;
  logic [4:0] rises_q;
  logic [2:0] age_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Helper counts; reset values let the first convert pass
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_q <= 8'hFF;
      rises_q <= 5'h10;
      age_q <= 3'h7;
    end else begin
      if ($rose(convert_start))
        gap_q <= 8'h00;
      else if (gap_q != 8'hFF)
        gap_q <= gap_q + 8'h01;
      if ($rose(convert_start))
        rises_q <= 5'h00;
      else if ($rose(sck))
        rises_q <= rises_q + 5'h01;
      // Saturates so a long idle never wraps into a false cause
      if ($rose(sck))
        age_q <= 3'h0;
      else if (age_q != 3'h7)
        age_q <= age_q + 3'h1;
    end
  end
  // Steps of one conversion
  sequence s_cnv;
    $rose(convert_start);
  endsequence
  sequence s_busy_run;
    busy [*5] ##1 !busy;
  endsequence
  // Device side timing and output control
  a_busy_starts: assert property (s_cnv |-> ##[1:5] $rose(busy))
    else $error("busy missing after convert");
  a_busy_length: assert property ($rose(busy) |-> s_busy_run)
    else $error("busy length wrong");
  a_sdo_cause: assert property ($changed(sdo_o) |->
    $fell(busy) || age_q <= 3'h4)
    else $error("data moved without cause");
  a_out_enable: assert property (
    (!chain && !read_enable_or_chain_in) [*4] |-> sdo_oe)
    else $error("output not driven when enabled");
  a_chain_drive: assert property (chain [*4] |-> sdo_oe)
    else $error("chain output not driven");
  // Host side spacing and readout
  a_cnv_spacing: assert property (s_cnv |-> gap_q >= CYC_CYC - 1)
    else $error("convert edges too close");
  a_cnv_idle: assert property (s_cnv |-> !busy)
    else $error("convert while busy");
  a_sck_quiet: assert property (s_cnv |-> !sck ##1 !sck)
    else $error("serial clock not quiet");
  a_full_readout: assert property (s_cnv |-> rises_q == 5'h10)
    else $error("readout incomplete");
  a_sck_period: assert property ($changed(sck) |=> $stable(sck))
    else $error("serial clock too fast");
endmodule

// ---- sar_pkg.sv ----
// Shared constants for the converter readout link and its host
package sar_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  // Conversion time window
  localparam int CONV_MIN_NS = 460;
  localparam int CONV_MAX_NS = 527;
  localparam int CONV_MIN_CYC = (CONV_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_NS;
  // Busy length actually used, inside the window
  localparam int CONV_CYC = CONV_MIN_CYC;
  // Host side spacing
  localparam int CYC_US = 1;
  localparam int CYC_CYC = (CYC_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int CNV_HL_NS = 20;
  localparam int CNV_HL_CYC = (CNV_HL_NS + CLK_NS - 1) / CLK_NS;
  localparam int QUIET_NS = 20;
  localparam int QUIET_CYC = (QUIET_NS + CLK_NS - 1) / CLK_NS;
  // Serial clock half period made by the host divider; two halves of three
  // cycles cover the device's two-flop input lag plus the host's own sync lag
  localparam int SCK_HALF_CYC = 3;
  localparam int RES_BITS = 16;
  // Reset values
  localparam logic [15:0] RESULT_RST = 16'h0000;
endpackage

// ---- testbench.sv ----
// Self-checking bench for converter and host joined by the link
`timescale 1ns/1ns
module testbench;
  import sar_pkg::*;
  logic clk, rst, start, chain_sel, ready, result_valid, gcs, sck_d;
  logic [15:0] result, code, wire_q, eb;
  int bad_count, n_tests, k, t;
  // Rows: code, no-scaling select, chain select
  logic [17:0] rows [6] = '{18'h00002, 18'h3FFFE, 18'h1FFFF, 18'h00000,
    18'h3FFFD, 18'h20004};
  sar_link_if link();
  sar_link_if link_b();
  sar_dev u_sar_dev (.clk(clk), .rst(rst), .link(link), .sample_code(code),
    .gain_compression_select(gcs));
  // Second converter faces the bench, which breaks host rules on it
  sar_dev u_sar_dev_b (.clk(clk), .rst(rst), .link(link_b),
    .sample_code(code), .gain_compression_select(1'b1));
  sar_host u_sar_host (.clk(clk), .rst(rst), .link(link), .start(start),
    .chain_sel(chain_sel), .ready(ready), .result(result),
    .result_valid(result_valid));
  sar_link_monitor u_sar_link_monitor (.clk(clk), .rst(rst),
    .convert_start(link.convert_start), .busy(link.busy), .sck(link.sck),
    .chain(link.chain), .read_enable_or_chain_in(link.read_enable_or_chain_in),
    .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe));
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Word seen on the wire, one bit per serial clock rise; sampled on
  // the falling edge so host outputs have settled
  always @(negedge clk) begin
    sck_d <= link.sck;
    if (link.sck === 1'b1 && sck_d === 1'b0)
      wire_q <= {wire_q[14:0], link.sdo};
  end
  // Expected word: optional 4/5 scale plus offset, then sign flip
  function automatic logic [15:0] exp_of(input logic [15:0] c,
    input logic g);
    logic [17:0] s;
    s = g ? {2'h0, c} : {2'h0, c} * 18'h00004 / 18'h00005 + 18'h0199A;
    return s[15:0] ^ 16'h8000;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    n_tests++;
    if (got !== want) begin
      $display("unexpected at %0t: got %h want %h", $time, got, want);
      bad_count++;
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Start held for n conversions; start drops once the last one begins
  task automatic run(input logic [17:0] row, input int n);
    logic [15:0] e;
    e = exp_of(row[17:2], row[1]);
    code = row[17:2];
    gcs = row[1];
    chain_sel = row[0];
    start = 1'b1;
    for (int i = n; i > 0; i--) begin
      for (k = 0; k < 40 && link.busy !== 1'b1; k++) @(negedge clk);
      if (i == 1)
        start = 1'b0;
      for (k = 0; k < 40 && link.busy !== 1'b0; k++) @(negedge clk);
      chk({15'h0000, link.sdo}, {15'h0000, e[15]});
      for (k = 0; k < 200 && result_valid !== 1'b1; k++) @(negedge clk);
      chk(result, e);
      chk(wire_q, e);
      @(negedge clk);
    end
    $display("test %0d done", t);
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    start = 1'b0;
    chain_sel = 1'b0;
    gcs = 1'b1;
    code = 16'h0000;
    link_b.convert_start = 1'b0;
    link_b.sck = 1'b0;
    link_b.chain = 1'b0;
    link_b.read_enable_or_chain_in = 1'b0;
    bad_count = 0;
    n_tests = 0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    for (t = 0; t < 6; t++) run(rows[t], 1);
    run(rows[1], 2);
    // Reset in mid-conversion, then a chain-mode transfer
    t++;
    start = 1'b1;
    for (k = 0; k < 40 && link.busy !== 1'b1; k++) @(negedge clk);
    rst = 1'b1;
    start = 1'b0;
    @(negedge clk);
    chk({15'h0000, link.busy}, 16'h0000);
    chk({15'h0000, ready}, 16'h0001);
    rst = 1'b0;
    run(rows[4], 1);
    // Second convert edge during busy must be ignored
    t++;
    eb = exp_of(code, 1'b1);
    link_b.convert_start = 1'b1;
    for (k = 0; k < 40 && link_b.busy !== 1'b1; k++) @(negedge clk);
    link_b.convert_start = 1'b0;
    @(negedge clk);
    link_b.convert_start = 1'b1;
    for (k = 0; k < 20 && link_b.busy === 1'b1; k++) @(negedge clk);
    chk(k[15:0], 16'(CONV_CYC - 1));
    chk({15'h0000, link_b.sdo}, {15'h0000, eb[15]});
    for (k = 0; k < 12 && link_b.busy !== 1'b1; k++) @(negedge clk);
    chk(k[15:0], 16'h000C);
    // Read enable high releases the line to its pull-up
    link_b.read_enable_or_chain_in = 1'b1;
    repeat (4) @(negedge clk);
    chk({15'h0000, link_b.sdo_oe}, 16'h0000);
    chk({15'h0000, link_b.sdo}, 16'h0001);
    $display("test %0d done", t);
    tally_and_finish();
  end
  // Watchdog, about four times the expected run
  initial begin
    repeat (4000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule
